/* File: design/sffd_pkg.sv */
package sffd_pkg;
    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] STATUS_OFF = 8'h00;
    localparam logic [7:0] TXTRIG_OFF = 8'h04;
    localparam logic [7:0] RXTRIG_OFF = 8'h08;
    localparam logic [7:0] LEVEL_OFF = 8'h0c;
    // Status register field positions.
    localparam int TX_FLAG_BIT = 0;
    localparam int RX_FLAG_BIT = 1;
    // Reset values of the trigger counts.
    localparam logic [4:0] TXTRIG_RST = 5'h08;
    localparam logic [4:0] RXTRIG_RST = 5'h08;
    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // FIFO level pair reported to software.
    typedef struct packed {
        logic [4:0] rx_level;
        logic [4:0] tx_level;
    } sffd_levels_t;
endpackage : sffd_pkg

/* File: design/sffd_flags.sv */
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Transmit request follows the transmit-empty flag.
// - Transmit request also starts the DMA controller.
// - Clear transmit flag: read one, then write zero.
// - Receive request follows the receive-full flag.
// - Receive-full flag starts DMA drain.
// - Clear receive flag: read one, then write zero.
// - Transmit flag resets while level at or below trigger.
// - Receive flag resets while level above trigger.
module sffd_flags (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // FIFO levels from the serial port.
    input wire sffd_pkg::sffd_levels_t levels,
    // Requests to CPU and DMA controller.
    output logic tx_irq_request,
    output logic rx_irq_request,
    output logic tx_dma_request,
    output logic rx_dma_request,
    // AXI4-Lite write address and data.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Held write address and data, with capture flags.
    logic [7:0] aw_q;
    logic aw_have_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    logic w_have_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    // Flags, trigger counts and the read-as-one arming bits.
    logic tx_flag_q;
    logic rx_flag_q;
    logic tx_armed_q;
    logic rx_armed_q;
    logic [4:0] tx_trig_q;
    logic [4:0] rx_trig_q;

    // Decode helper used for both address channels.
    function automatic logic is_mapped(input logic [7:0] a);
        return a == sffd_pkg::STATUS_OFF || a == sffd_pkg::TXTRIG_OFF ||
               a == sffd_pkg::RXTRIG_OFF || a == sffd_pkg::LEVEL_OFF;
    endfunction : is_mapped

    // Handshake decode; one write and one read outstanding at most.
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    wire wr_fire = aw_have_q && w_have_q && !bvalid_q;
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire wr_status = wr_fire && aw_q == sffd_pkg::STATUS_OFF && ws_q[0];
    wire rd_status = rd_fire && s_axi_araddr == sffd_pkg::STATUS_OFF;

    // Level conditions that force the flags to stay set.
    wire tx_cond = levels.tx_level <= tx_trig_q;
    wire rx_cond = levels.rx_level > rx_trig_q;
    // A write of zero clears only after the flag was read as one.
    wire tx_clr = wr_status && !w_q[sffd_pkg::TX_FLAG_BIT] && tx_armed_q;
    wire rx_clr = wr_status && !w_q[sffd_pkg::RX_FLAG_BIT] && rx_armed_q;
    // Set wins over clear so an event in the clear cycle is kept.
    wire tx_flag_d = tx_cond || (tx_flag_q && !tx_clr);
    wire rx_flag_d = rx_cond || (rx_flag_q && !rx_clr);

    // Requests are plain copies of the flags, shared by CPU and DMA.
    // Plain wires keep the DMA controller one cycle closer to the flag.
    assign tx_irq_request = tx_flag_q;
    assign tx_dma_request = tx_flag_q;
    assign rx_irq_request = rx_flag_q;
    assign rx_dma_request = rx_flag_q;

    // Read data mux; unmapped reads return zero with an error code.
    wire [31:0] rd_mux =
        s_axi_araddr == sffd_pkg::STATUS_OFF ? {30'h0, rx_flag_q, tx_flag_q} :
        s_axi_araddr == sffd_pkg::TXTRIG_OFF ? {27'h0, tx_trig_q} :
        s_axi_araddr == sffd_pkg::RXTRIG_OFF ? {27'h0, rx_trig_q} :
        s_axi_araddr == sffd_pkg::LEVEL_OFF ? {22'h0, levels} : 32'h0;

    // Write channel capture, taken in either order.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_q <= 8'h00;
            aw_have_q <= 1'b0;
            w_q <= 32'h0;
            ws_q <= 4'h0;
            w_have_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // Write response, held until the master takes it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= sffd_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(aw_q) ? sffd_pkg::RESP_OKAY : sffd_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read response, held until the master takes it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= sffd_pkg::RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= is_mapped(s_axi_araddr) ? sffd_pkg::RESP_OKAY : sffd_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Trigger counts; only the low byte lane carries them.
    // A new count reaches the flags one edge after the count register loads it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_trig_q <= sffd_pkg::TXTRIG_RST;
            rx_trig_q <= sffd_pkg::RXTRIG_RST;
        end else if (wr_fire && ws_q[0]) begin
            if (aw_q == sffd_pkg::TXTRIG_OFF) tx_trig_q <= w_q[4:0];
            if (aw_q == sffd_pkg::RXTRIG_OFF) rx_trig_q <= w_q[4:0];
        end
    end

    // Flags and arming. Arming records a read of one; a status write with byte lane 0 on
    // consumes it, so a blind zero write without a prior read is ignored.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_flag_q <= 1'b0;
            rx_flag_q <= 1'b0;
            tx_armed_q <= 1'b0;
            rx_armed_q <= 1'b0;
        end else begin
            tx_flag_q <= tx_flag_d;
            rx_flag_q <= rx_flag_d;
            if (rd_status && tx_flag_q) tx_armed_q <= 1'b1;
            else if (wr_status || !tx_flag_q) tx_armed_q <= 1'b0;
            if (rd_status && rx_flag_q) rx_armed_q <= 1'b1;
            else if (wr_status || !rx_flag_q) rx_armed_q <= 1'b0;
        end
    end

    // Checks beside the logic they guard.
    tx_req_follow_a: assert property (@(posedge clk) disable iff (rst)
        tx_irq_request == tx_flag_q && tx_dma_request == tx_flag_q)
        else $error("tx request differs from flag");
    rx_req_follow_a: assert property (@(posedge clk) disable iff (rst)
        rx_irq_request == rx_flag_q && rx_dma_request == rx_flag_q)
        else $error("rx request differs from flag");
    tx_dma_src_a: assert property (@(posedge clk) disable iff (rst)
        $rose(tx_flag_q) |-> tx_dma_request)
        else $error("tx dma request missing");
    rx_dma_src_a: assert property (@(posedge clk) disable iff (rst)
        $rose(rx_flag_q) |-> rx_dma_request)
        else $error("rx dma request missing");
    tx_reset_set_a: assert property (@(posedge clk) disable iff (rst)
        tx_cond |=> tx_flag_q)
        else $error("tx flag not set at low level");
    rx_reset_set_a: assert property (@(posedge clk) disable iff (rst)
        rx_cond |=> rx_flag_q)
        else $error("rx flag not set at high level");
    tx_blind_clr_a: assert property (@(posedge clk) disable iff (rst)
        tx_flag_q && !tx_armed_q |=> tx_flag_q)
        else $error("tx flag cleared without read");
    rx_blind_clr_a: assert property (@(posedge clk) disable iff (rst)
        rx_flag_q && !rx_armed_q |=> rx_flag_q)
        else $error("rx flag cleared without read");
    tx_clear_cov: cover property (@(posedge clk) disable iff (rst) tx_clr && !tx_cond);
    rx_clear_cov: cover property (@(posedge clk) disable iff (rst) rx_clr && !rx_cond);
    tx_reset_cov: cover property (@(posedge clk) disable iff (rst) tx_clr && tx_cond);
    rx_reset_cov: cover property (@(posedge clk) disable iff (rst) rx_clr && rx_cond);

    // A request may only drop through the read-one, write-zero clear path.
    tx_clear_path_a: assert property (@(posedge clk) disable iff (rst)
        $fell(tx_irq_request) |-> $past(tx_armed_q) && $past(wr_status) && !$past(tx_cond))
        else $error("tx request dropped without clear");
    rx_clear_path_a: assert property (@(posedge clk) disable iff (rst)
        $fell(rx_irq_request) |-> $past(rx_armed_q) && $past(wr_status) && !$past(rx_cond))
        else $error("rx request dropped without clear");
endmodule : sffd_flags

/* File: sim/sffd_fifo_model.sv */
`timescale 1ns/1ps
// Byte counts of both FIFOs; the servicing side moves one byte a cycle.
module sffd_fifo_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Byte moves: tx refill, rx arrival, rx drain.
    input wire logic tx_put,
    input wire logic rx_put,
    input wire logic rx_get,
    // Levels seen by the flag logic.
    output sffd_pkg::sffd_levels_t levels
);
    // The drain stops at zero, so a stray pop cannot wrap the count.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            levels <= '0;
        end else begin
            levels.tx_level <= levels.tx_level + 5'(tx_put);
            levels.rx_level <= levels.rx_level + 5'(rx_put) - 5'(rx_get && |levels.rx_level);
        end
    end
endmodule : sffd_fifo_model

/* File: sim/tb_sffd_flags.sv */
`timescale 1ns/1ps
module tb_sffd_flags;
    // Clock, reset and the byte-move strobes: bit 0 tx refill, 1 rx arrival, 2 rx drain.
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] mv = 3'h0;
    // Master side of the register bus.
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic awr, wr, bv, arr, rv, ti, td, ri, rd;
    logic [7:0] aa = 8'h00, ra = 8'h00;
    logic [31:0] wd = 32'h0, rdt, q;
    logic [3:0] ws = 4'hf;
    logic [1:0] bres, rres, qr, qb;
    sffd_pkg::sffd_levels_t lv;
    int mismatches = 0, n_compared = 0, cyc = 0;
    sffd_fifo_model fm_u (.clk(clk), .rst(rst), .tx_put(mv[0]), .rx_put(mv[1]), .rx_get(mv[2]),
        .levels(lv));
    sffd_flags dut_u (.clk(clk), .rst(rst), .levels(lv), .tx_irq_request(ti),
        .rx_irq_request(ri), .tx_dma_request(td), .rx_dma_request(rd), .s_axi_awaddr(aa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bres), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdt), .s_axi_rresp(rres), .s_axi_rvalid(rv), .s_axi_rready(rr));
    // Clock at 40 MHz.
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Each channel is judged at the rising edge, on the values that stood before it.
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        logic gb;
        gb = 1'b0;
        @(posedge clk);
        aa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        while (!gb) begin
            @(posedge clk);
            gb = bv && br;
            qb = bres;
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (gb) br <= 1'b0;
        end
    endtask : wr32
    task automatic rd32(input logic [7:0] a);
        logic gr;
        gr = 1'b0;
        @(posedge clk);
        ra <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        while (!gr) begin
            @(posedge clk);
            gr = rv && rr;
            q = rdt;
            qr = rres;
            if (arv && arr) arv <= 1'b0;
            if (gr) rr <= 1'b0;
        end
    endtask : rd32
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Holds byte-move strobe b high for n edges, then lets two edges settle.
    task automatic moves(input int b, input int n);
        @(posedge clk);
        mv[b] <= 1'b1;
        repeat (n) @(posedge clk);
        mv[b] <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : moves
    task automatic print_verdict();
        if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // Guards against a slave that never answers.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(ti), 32'h00000001);
        chk(32'(td), 32'h00000001);
        chk(32'(ri), 32'h00000000);
        chk(32'(rd), 32'h00000000);
        rd32(sffd_pkg::TXTRIG_OFF);
        chk(q, 32'(sffd_pkg::TXTRIG_RST));
        rd32(8'h10);
        chk(q, 32'h00000000);
        chk(32'(qr), 32'(sffd_pkg::RESP_SLVERR));
        // An empty tx FIFO keeps its flag set through a clear.
        rd32(sffd_pkg::STATUS_OFF);
        chk(q, 32'h00000001);
        wr32(sffd_pkg::STATUS_OFF, 32'h0);
        chk(32'(qb), 32'(sffd_pkg::RESP_OKAY));
        chk(32'(ti), 32'h00000001);
        // Fill past the trigger; a blind zero write must leave the flag set.
        moves(0, 9);
        wr32(sffd_pkg::STATUS_OFF, 32'h0);
        chk(32'(ti), 32'h00000001);
        rd32(sffd_pkg::STATUS_OFF);
        chk(q, 32'h00000001);
        wr32(sffd_pkg::STATUS_OFF, 32'h0);
        chk(32'(ti), 32'h00000000);
        chk(32'(td), 32'h00000000);
        // Receive data above the trigger raises both receive requests.
        moves(1, 9);
        chk(32'(ri), 32'h00000001);
        chk(32'(rd), 32'h00000001);
        rd32(sffd_pkg::STATUS_OFF);
        wr32(sffd_pkg::STATUS_OFF, 32'h0);
        chk(32'(ri), 32'h00000001);
        moves(2, 1);
        rd32(sffd_pkg::STATUS_OFF);
        chk(q, 32'h00000002);
        wr32(sffd_pkg::STATUS_OFF, 32'h0);
        chk(32'(ri), 32'h00000000);
        chk(32'(rd), 32'h00000000);
        rd32(sffd_pkg::LEVEL_OFF);
        chk(q, 32'h00000109);
        // New trigger counts put the present levels on the set side.
        wr32(sffd_pkg::TXTRIG_OFF, 32'h0000000a);
        wr32(sffd_pkg::RXTRIG_OFF, 32'h00000002);
        @(posedge clk);
        chk(32'(ti), 32'h00000001);
        chk(32'(ri), 32'h00000001);
        // A write with the low byte lane off leaves the trigger alone.
        ws <= 4'h0;
        wr32(sffd_pkg::TXTRIG_OFF, 32'h00000001);
        ws <= 4'hf;
        chk(32'(qb), 32'(sffd_pkg::RESP_OKAY));
        rd32(sffd_pkg::TXTRIG_OFF);
        chk(q, 32'h0000000a);
        wr32(8'h10, 32'h0);
        chk(32'(qb), 32'(sffd_pkg::RESP_SLVERR));
        // A second reset restores the triggers and re-evaluates both flags.
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk(32'(ti), 32'h00000001);
        chk(32'(ri), 32'h00000000);
        rd32(sffd_pkg::RXTRIG_OFF);
        chk(q, 32'(sffd_pkg::RXTRIG_RST));
        print_verdict();
    end
endmodule : tb_sffd_flags
